//--- test_latch_pkg.sv
/*
 Shared constants, layouts and helper functions for the position converter
 test and latch logic. Assumes a 25 MHz core clock and 16-bit data words.
*/
package test_latch_pkg;
   // channel counts and word width
   localparam int MEAS_CH = 8;
   localparam int STIM_PAIRS = 6;
   localparam int STIM_OUTS = 12;
   localparam int WORD_W = 16;
   localparam int CLK_NS = 40;

   // check tolerances in parts per million of full scale
   localparam int FS_COUNTS = 65536;
   localparam int TOL_MEAS_PPM = 1000;
   localparam int TOL_STIM_PPM = 2000;
   localparam logic [16:0] TOL_MEAS_CNT = 17'(FS_COUNTS * TOL_MEAS_PPM / 1000000);
   localparam logic [16:0] TOL_STIM_CNT = 17'(FS_COUNTS * TOL_STIM_PPM / 1000000);

   // initiated test sequence
   localparam int INIT_STEPS = 20;
   localparam logic [4:0] STEP_LAST = 5'(INIT_STEPS - 1);
   localparam int SETTLE_NS = 20000;
   localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int WAIT_W = $clog2(SETTLE_CYC);
   localparam logic [WAIT_W-1:0] SETTLE_LAST = WAIT_W'(SETTLE_CYC - 1);
   localparam logic [15:0] POS_BASE = 16'h9000;
   localparam logic [15:0] POS_STEP = 16'h0c00;

   // ratio computation
   localparam logic [16:0] REF_TWO_WIRE = 17'h08000;
   localparam logic [15:0] RATIO_MAX = 16'h7fff;
   localparam logic [4:0] DIV_ITER = 5'h10;

   // synchronised pin vector layout
   localparam int PIN_MSIG = 0;
   localparam int PIN_MEXC = 8;
   localparam int PIN_SSIG = 16;
   localparam int PIN_SEXC = 22;
   localparam int PIN_KICK = 28;
   localparam int PIN_W = 29;

   // magnitude of the difference of two signed words
   function automatic logic [16:0] adiff(input logic [15:0] a, input logic [15:0] b);
      logic signed [16:0] d;
      d = signed'({a[15], a}) - signed'({b[15], b});
      return d[16] ? 17'(-d) : 17'(d);
   endfunction

   // stimulus position used at a given step of the initiated test
   function automatic logic [15:0] step_pos(input logic [4:0] step);
      return 16'(POS_BASE + 16'(step) * POS_STEP);
   endfunction
endpackage

//--- ratio_if.sv
/*
 Request and answer signals between the core and the ratio divider.
 Assumes both ends run on the same core clock.
*/
`timescale 1ns/10ps
interface ratio_if;
   logic start;
   logic busy;
   logic done;
   logic signed [16:0] num;
   logic [16:0] den;
   logic signed [15:0] quo;

   modport requester (output start, output num, output den, input busy, input done, input quo);
   modport solver (input start, input num, input den, output busy, output done, output quo);
endinterface

//--- ratio_divider.sv
/*
 Sequential divider giving num * 2^15 / den as a saturated signed word.
 Assumes |num| <= 2 * den in normal use; takes 16 iterations per request.
*/
`timescale 1ns/10ps
module ratio_divider
   import test_latch_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // request and answer
   ratio_if.solver rq
);
   typedef struct packed {
      logic busy;
      logic done;
      logic neg;
      logic zero;
      logic [4:0] k;
      logic [17:0] rem;
      logic [16:0] den;
      logic [15:0] q;
      logic signed [15:0] quo;
   } div_t;

   div_t s_q;
   div_t s_d;

   // one restoring step per cycle keeps the area to one subtractor
   always_comb
   begin
      logic ge;
      logic [15:0] qf;
      logic [15:0] mag;
      ge = 1'b0;
      qf = '0;
      mag = '0;
      s_d = s_q;
      s_d.done = 1'b0;
      if (!s_q.busy)
      begin
         if (rq.start)
         begin
            s_d.busy = 1'b1;
            s_d.k = DIV_ITER;
            s_d.neg = rq.num[16];
            s_d.rem = {1'b0, 17'(rq.num[16] ? -rq.num : rq.num)};
            s_d.den = rq.den;
            s_d.zero = (rq.den == '0);
            s_d.q = '0;
         end
      end
      else
      begin
         ge = (s_q.rem >= {1'b0, s_q.den});
         qf = {s_q.q[14:0], ge};
         s_d.q = qf;
         s_d.rem = (ge ? s_q.rem - {1'b0, s_q.den} : s_q.rem) << 1;
         s_d.k = s_q.k - 5'h01;
         if (s_q.k == 5'h01)
         begin
            mag = qf[15] ? RATIO_MAX : qf; // full deflection saturates
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
            s_d.quo = s_q.zero ? '0 : (s_q.neg ? -signed'(mag) : signed'(mag));
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign rq.busy = s_q.busy;
   assign rq.done = s_q.done;
   assign rq.quo = s_q.quo;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   chk_div_latency: assert property (rq.start && !rq.busy |-> ##17 rq.done)
      else $error("divider answer not after sixteen steps");
endmodule

//--- cpu_watchdog.sv
/*
 Watchdog that flags a stalled on-board processor.
 Assumes kick is a one-cycle pulse on the core clock.
*/
`timescale 1ns/10ps
module cpu_watchdog #(
   parameter int TIMEOUT_CYC = 25000000
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // supervision
   input wire logic kick,
   output logic expired
);
   localparam int CNT_W = $clog2(TIMEOUT_CYC + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TIMEOUT_CYC - 1);

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic expired;
   } wdog_t;

   wdog_t s_q;
   wdog_t s_d;

   if (TIMEOUT_CYC < 2)
      $error("watchdog timeout too short");

   // expiry stays until the processor kicks again
   always_comb
   begin
      s_d = s_q;
      if (kick)
      begin
         s_d.cnt = '0;
         s_d.expired = 1'b0;
      end
      else if (s_q.cnt == CNT_LAST)
         s_d.expired = 1'b1;
      else
         s_d.cnt = s_q.cnt + 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign expired = s_q.expired;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   chk_wdog_expiry: assert property (s_q.cnt == CNT_LAST && !kick |=> expired)
      else $error("watchdog missed its timeout");
   cov_wdog_bite: cover property ($rose(expired));
endmodule

//--- position_converter_test_latch.sv
/*
 Latch, ratio, self-test and supervision core for eight measurement and
 six stimulus pair channels. Assumes the host logic drives the control
 ports on CORE_CLK; presence and kick pins come from outside and are
 synchronised here.
*/
`timescale 1ns/10ps
// Contract
// - latch command freezes all channels together
// - reading latched channel releases only that one
// - unlatched reads return newest result, no waits
// - data and commands are 16-bit words
// - malfunctions flagged within five seconds, unpolled
// - background test enable, transparent to operation
// - background stimulus compare, 0.2% FS limit
// - background measurement check, 0.1% FS limit
// - signal and excitation loss per channel
// - background failure interrupts only when enabled
// - initiated measurement test isolates, checks 0.1%
// - initiated stimulus test steps twenty positions
// - stimulus outputs stay driven during test
// - host starts and stops initiated test
// - initiated failure interrupts when enabled
// - loopback isolates inputs, host writes/reads back
// - loopback leaves stimulus channels alone
// - ratio (A-B)/(A+B), or A over reference
// - watchdog supervises on-board processor
// - identity words readable from nonvolatile store; here fixed by the PART_ID to REV_ID parameters
// - two-wire pair drives outputs from own words
module position_converter_test_latch
   import test_latch_pkg::*;
#(
   parameter int WDOG_CYC = 25000000,
   parameter logic [15:0] PART_ID = 16'h1234, // arbitrary value
   parameter logic [15:0] SERIAL_ID = 16'h0001, // arbitrary value
   parameter logic [15:0] DATE_ID = 16'h0101, // arbitrary value
   parameter logic [15:0] REV_ID = 16'h0010 // arbitrary value
) (
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RSTN,
   // test mode controls
   input wire logic BACKGROUND_CHECK_ENABLE,
   input wire logic INITIATED_CHECK_START,
   input wire logic INTERFACE_LOOPBACK_CHECK,
   input wire logic IRQ_EN_BG,
   input wire logic IRQ_EN_INIT,
   input wire logic STATUS_CLR,
   // latch and read
   input wire logic LATCH_CMD,
   input wire logic RD_STB,
   input wire logic [2:0] RD_CHAN,
   output logic [15:0] RD_DATA,
   // loopback writes
   input wire logic LB_WR_STB,
   input wire logic [2:0] LB_WR_CHAN,
   input wire logic [15:0] LB_WR_DATA,
   // converter front end
   input wire logic [MEAS_CH-1:0][15:0] SEC_A,
   input wire logic [MEAS_CH-1:0][15:0] SEC_B,
   input wire logic [MEAS_CH-1:0] MEAS_WIRE34,
   input wire logic [MEAS_CH-1:0][15:0] MEAS_BIT_REF,
   output logic MEAS_ISOLATE,
   output logic [15:0] TEST_LEVEL,
   // stimulus channels
   input wire logic [STIM_OUTS-1:0][15:0] STIM_POS,
   input wire logic [STIM_PAIRS-1:0] STIM_WIRE34,
   input wire logic [STIM_PAIRS-1:0] STIM_ON,
   input wire logic [STIM_OUTS-1:0][15:0] STIM_WRAP,
   output logic [STIM_OUTS-1:0][15:0] STIM_CMD,
   output logic [STIM_PAIRS-1:0] STIM_DRIVE,
   // supervision pins
   input wire logic [MEAS_CH-1:0] MEAS_SIG_OK,
   input wire logic [MEAS_CH-1:0] MEAS_EXC_OK,
   input wire logic [STIM_PAIRS-1:0] STIM_SIG_OK,
   input wire logic [STIM_PAIRS-1:0] STIM_EXC_OK,
   input wire logic CPU_KICK,
   output logic CPU_RST_REQ,
   // status
   output logic [MEAS_CH-1:0] MEAS_FAIL,
   output logic [MEAS_CH-1:0] MEAS_SIG_LOSS,
   output logic [MEAS_CH-1:0] MEAS_EXC_LOSS,
   output logic [STIM_OUTS-1:0] STIM_FAIL,
   output logic [STIM_PAIRS-1:0] STIM_SIG_LOSS,
   output logic [STIM_PAIRS-1:0] STIM_EXC_LOSS,
   output logic INIT_BUSY,
   output logic INIT_DONE_FLAG,
   output logic IRQ,
   // identity
   output logic [15:0] PART_NUM,
   output logic [15:0] SERIAL_NUM,
   output logic [15:0] DATE_CODE,
   output logic [15:0] REV_LEVEL
);
   typedef enum logic [1:0] {INIT_IDLE, INIT_SETTLE, INIT_CHECK, INIT_DONE} init_state_t;

   typedef struct packed {
      logic [PIN_W-1:0] sync1;
      logic [PIN_W-1:0] sync2;
      logic [PIN_W-1:0] sync3;
      logic [PIN_W-1:0] filt;
      logic kick_q;
      logic [MEAS_CH-1:0][15:0] live;
      logic [MEAS_CH-1:0][15:0] snap;
      logic [MEAS_CH-1:0] latched;
      logic [15:0] rd_data;
      logic [2:0] ch;
      logic [STIM_OUTS-1:0][15:0] cmd;
      logic [STIM_PAIRS-1:0] drive;
      logic [15:0] test_lvl;
      logic [MEAS_CH-1:0] meas_fail;
      logic [MEAS_CH-1:0] meas_sig_loss;
      logic [MEAS_CH-1:0] meas_exc_loss;
      logic [STIM_OUTS-1:0] stim_fail;
      logic [STIM_PAIRS-1:0] stim_sig_loss;
      logic [STIM_PAIRS-1:0] stim_exc_loss;
      logic bg_hit;
      logic init_hit;
      logic irq;
      init_state_t state;
      logic [4:0] step;
      logic [WAIT_W-1:0] wait_cnt;
   } core_t;

   core_t s_q;
   core_t s_d;
   logic [PIN_W-1:0] pins;
   logic init_act;
   logic bg_act;
   logic kick;

   ratio_if div ();

   if (WDOG_CYC < 2)
      $error("WDOG_CYC must be at least 2");

   // sequential divider shared by all eight channels, round robin
   ratio_divider u_div (
      .clk(CORE_CLK),
      .rst_n(RSTN),
      .rq(div)
   );

   cpu_watchdog #(
      .TIMEOUT_CYC(WDOG_CYC)
   ) u_wdog (
      .clk(CORE_CLK),
      .rst_n(RSTN),
      .kick(kick),
      .expired(CPU_RST_REQ)
   );

   // ratio request for the channel whose turn it is
   assign div.start = !div.busy && !div.done;
   assign div.num = MEAS_WIRE34[s_q.ch] ?
      signed'({1'b0, SEC_A[s_q.ch]}) - signed'({1'b0, SEC_B[s_q.ch]}) :
      signed'({SEC_A[s_q.ch][15], SEC_A[s_q.ch]});
   assign div.den = MEAS_WIRE34[s_q.ch] ?
      {1'b0, SEC_A[s_q.ch]} + {1'b0, SEC_B[s_q.ch]} : REF_TWO_WIRE;

   // mode decode shared by the next-state logic and the ports
   assign pins = {CPU_KICK, STIM_EXC_OK, STIM_SIG_OK, MEAS_EXC_OK, MEAS_SIG_OK};
   assign init_act = (s_q.state == INIT_SETTLE) || (s_q.state == INIT_CHECK);
   assign bg_act = BACKGROUND_CHECK_ENABLE && !init_act && !INTERFACE_LOOPBACK_CHECK;
   assign kick = s_q.filt[PIN_KICK] != s_q.kick_q;

   // whole next state; clears come first so a same-cycle set wins
   always_comb
   begin
      logic [15:0] tp;
      tp = step_pos(s_q.step);
      s_d = s_q;

      // three-stage pin synchroniser, change taken once stages agree
      s_d.sync1 = pins;
      s_d.sync2 = s_q.sync1;
      s_d.sync3 = s_q.sync2;
      for (int i = 0; i < PIN_W; i++)
      begin
         if (s_q.sync2[i] == s_q.sync3[i])
            s_d.filt[i] = s_q.sync2[i];
      end
      s_d.kick_q = s_q.filt[PIN_KICK];

      // converter results keep tracking whatever the latch does
      if (div.done)
      begin
         if (!INTERFACE_LOOPBACK_CHECK)
            s_d.live[s_q.ch] = div.quo;
         s_d.ch = s_q.ch + 3'h1;
      end
      if (INTERFACE_LOOPBACK_CHECK && LB_WR_STB)
         s_d.live[LB_WR_CHAN] = LB_WR_DATA;

      // read returns snapshot or live word and frees that channel
      if (RD_STB)
      begin
         s_d.rd_data = s_q.latched[RD_CHAN] ? s_q.snap[RD_CHAN] : s_q.live[RD_CHAN];
         s_d.latched[RD_CHAN] = 1'b0;
      end
      if (LATCH_CMD)
      begin
         s_d.snap = s_q.live;
         s_d.latched = '1;
      end

      // status clear by the host
      if (STATUS_CLR)
      begin
         s_d.meas_fail = '0;
         s_d.meas_sig_loss = '0;
         s_d.meas_exc_loss = '0;
         s_d.stim_fail = '0;
         s_d.stim_sig_loss = '0;
         s_d.stim_exc_loss = '0;
         s_d.bg_hit = 1'b0;
         s_d.init_hit = 1'b0;
      end

      // stimulus commands; a STIM_WIRE34 pair shares the A word, other pairs use their own words
      for (int p = 0; p < STIM_PAIRS; p++)
      begin
         if (init_act)
         begin
            s_d.cmd[2*p] = tp;
            s_d.cmd[2*p+1] = tp;
         end
         else
         begin
            s_d.cmd[2*p] = STIM_POS[2*p];
            s_d.cmd[2*p+1] = STIM_WIRE34[p] ? STIM_POS[2*p] : STIM_POS[2*p+1];
         end
      end
      s_d.drive = init_act ? '1 : STIM_ON;
      s_d.test_lvl = init_act ? tp : '0;

      // background checks run every cycle, far inside the alert limit
      if (bg_act)
      begin
         for (int k = 0; k < STIM_OUTS; k++)
         begin
            if (adiff(STIM_WRAP[k], s_q.cmd[k]) > TOL_STIM_CNT)
            begin
               s_d.stim_fail[k] = 1'b1;
               s_d.bg_hit = 1'b1;
            end
         end
         for (int c = 0; c < MEAS_CH; c++)
         begin
            if (adiff(s_q.live[c], MEAS_BIT_REF[c]) > TOL_MEAS_CNT)
            begin
               s_d.meas_fail[c] = 1'b1;
               s_d.bg_hit = 1'b1;
            end
            if (!s_q.filt[PIN_MSIG+c] || !s_q.filt[PIN_MEXC+c])
               s_d.bg_hit = 1'b1;
            if (!s_q.filt[PIN_MSIG+c])
               s_d.meas_sig_loss[c] = 1'b1;
            if (!s_q.filt[PIN_MEXC+c])
               s_d.meas_exc_loss[c] = 1'b1;
         end
         for (int p = 0; p < STIM_PAIRS; p++)
         begin
            if (!s_q.filt[PIN_SSIG+p] || !s_q.filt[PIN_SEXC+p])
               s_d.bg_hit = 1'b1;
            if (!s_q.filt[PIN_SSIG+p])
               s_d.stim_sig_loss[p] = 1'b1;
            if (!s_q.filt[PIN_SEXC+p])
               s_d.stim_exc_loss[p] = 1'b1;
         end
      end

      // initiated test sequencer; latch state is deliberately untouched
      case (s_q.state)
         INIT_IDLE:
         begin
            if (INITIATED_CHECK_START)
            begin
               s_d.state = INIT_SETTLE;
               s_d.step = '0;
               s_d.wait_cnt = '0;
            end
         end
         INIT_SETTLE:
         begin
            if (s_q.wait_cnt == SETTLE_LAST)
               s_d.state = INIT_CHECK;
            else
               s_d.wait_cnt = s_q.wait_cnt + 1'b1;
         end
         INIT_CHECK:
         begin
            for (int k = 0; k < STIM_OUTS; k++)
            begin
               if (adiff(STIM_WRAP[k], tp) > TOL_STIM_CNT)
               begin
                  s_d.stim_fail[k] = 1'b1;
                  s_d.init_hit = 1'b1;
               end
            end
            for (int c = 0; c < MEAS_CH; c++)
            begin
               if (adiff(s_q.live[c], tp) > TOL_MEAS_CNT)
               begin
                  s_d.meas_fail[c] = 1'b1;
                  s_d.init_hit = 1'b1;
               end
            end
            if (s_q.step == STEP_LAST)
               s_d.state = INIT_DONE;
            else
            begin
               s_d.step = s_q.step + 5'h01;
               s_d.wait_cnt = '0;
               s_d.state = INIT_SETTLE;
            end
         end
         INIT_DONE:
            s_d.state = INIT_DONE;
         default:
            s_d.state = INIT_IDLE;
      endcase
      if (!INITIATED_CHECK_START)
         s_d.state = INIT_IDLE;

      // interrupt follows sticky hits gated by the enables
      s_d.irq = (s_q.bg_hit && IRQ_EN_BG) || (s_q.init_hit && IRQ_EN_INIT);
   end

   // one register for the whole core; pins idle as present
   always_ff @(posedge CORE_CLK)
   begin
      if (!RSTN)
      begin
         s_q <= '0;
         s_q.sync1 <= '1;
         s_q.sync2 <= '1;
         s_q.sync3 <= '1;
         s_q.filt <= '1;
         s_q.kick_q <= 1'b1;
      end
      else
         s_q <= s_d;
   end

   // outputs
   assign RD_DATA = s_q.rd_data;
   assign MEAS_ISOLATE = init_act || INTERFACE_LOOPBACK_CHECK;
   assign TEST_LEVEL = s_q.test_lvl;
   assign STIM_CMD = s_q.cmd;
   assign STIM_DRIVE = s_q.drive;
   assign MEAS_FAIL = s_q.meas_fail;
   assign MEAS_SIG_LOSS = s_q.meas_sig_loss;
   assign MEAS_EXC_LOSS = s_q.meas_exc_loss;
   assign STIM_FAIL = s_q.stim_fail;
   assign STIM_SIG_LOSS = s_q.stim_sig_loss;
   assign STIM_EXC_LOSS = s_q.stim_exc_loss;
   assign INIT_BUSY = init_act;
   assign INIT_DONE_FLAG = s_q.state == INIT_DONE;
   assign IRQ = s_q.irq;
   assign PART_NUM = PART_ID;
   assign SERIAL_NUM = SERIAL_ID;
   assign DATE_CODE = DATE_ID;
   assign REV_LEVEL = REV_ID;

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RSTN);

   chk_latch_all: assert property (LATCH_CMD |=> &s_q.latched && s_q.snap == $past(s_q.live))
      else $error("latch did not freeze every channel");
   chk_read_unlatch: assert property (RD_STB && !LATCH_CMD
      |=> !s_q.latched[$past(RD_CHAN)]
      && (s_q.latched | (8'h01 << $past(RD_CHAN)))
      == ($past(s_q.latched) | (8'h01 << $past(RD_CHAN))))
      else $error("read released the wrong latch");
   chk_live_read: assert property (RD_STB && !s_q.latched[RD_CHAN]
      |=> RD_DATA == $past(s_q.live[RD_CHAN]))
      else $error("unlatched read not the newest word");
   chk_snap_read: assert property (RD_STB && s_q.latched[RD_CHAN]
      |=> RD_DATA == $past(s_q.snap[RD_CHAN]))
      else $error("latched read not the snapshot");
   // the flag must rise, and the interrupt follows the enable seen a cycle later
   chk_bg_stim_fail: assert property (bg_act
      && adiff(STIM_WRAP[0], s_q.cmd[0]) > TOL_STIM_CNT
      |=> STIM_FAIL[0] and (IRQ_EN_BG |=> IRQ))
      else $error("stimulus miscompare not flagged");
   chk_fail_sticky: assert property (MEAS_FAIL[0] && !STATUS_CLR |=> MEAS_FAIL[0])
      else $error("failure status dropped without clear");
   chk_irq_gate: assert property (!IRQ_EN_BG && !IRQ_EN_INIT |=> !IRQ)
      else $error("interrupt raised while disabled");
   chk_loop_write: assert property (INTERFACE_LOOPBACK_CHECK && LB_WR_STB
      |=> s_q.live[$past(LB_WR_CHAN)] == $past(LB_WR_DATA))
      else $error("loopback word not stored");
   chk_test_drive: assert property (INIT_BUSY ##1 INIT_BUSY |-> STIM_DRIVE == 6'h3f)
      else $error("stimulus outputs off during initiated test");
   chk_step_end: assert property (s_q.state == INIT_CHECK && s_q.step == STEP_LAST
      && INITIATED_CHECK_START |=> INIT_DONE_FLAG)
      else $error("initiated test did not end after last step");
   chk_pair_share: assert property (!init_act && STIM_WIRE34[0]
      |=> STIM_CMD[1] == $past(STIM_POS[0]) && STIM_CMD[0] == $past(STIM_POS[0]))
      else $error("paired output not from the shared word");
   chk_latch_kept: assert property ($rose(INITIATED_CHECK_START) && !RD_STB && !LATCH_CMD
      |=> s_q.latched == $past(s_q.latched))
      else $error("test start changed latch state");

   cov_latch_read: cover property (LATCH_CMD ##[1:8] RD_STB);
   cov_init_done: cover property ($rose(INIT_DONE_FLAG));
   cov_loopback: cover property (INTERFACE_LOOPBACK_CHECK && LB_WR_STB ##1 RD_STB);
   cov_bg_irq: cover property (bg_act && $rose(IRQ));
endmodule

//--- stim_wrap_model.sv
/*
 Wrap-around model of the stimulus outputs: digitised actual outputs.
 Assumes the core clock domain; an error can be added on output 0.
*/
`timescale 1ns/10ps
module stim_wrap_model
   import test_latch_pkg::*;
(
   // commands in, measured outputs back
   input wire logic [STIM_OUTS-1:0][15:0] cmd,
   input wire logic [15:0] off,
   output logic [STIM_OUTS-1:0][15:0] wrap
);
   // ideal follower, so only the injected error can trip a check
   always_comb
   begin
      wrap = cmd;
      wrap[0] = cmd[0] + off;
   end
endmodule

//--- tb.sv
/*
 Self-checking bench for the test and latch core.
 Assumes the package and the wrap model are compiled first.
*/
`timescale 1ns/10ps
module tb;
   import test_latch_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, bg = 1'b0, init = 1'b0, lb = 1'b0, ieb = 1'b0, clr = 1'b0;
   logic lat = 1'b0, rd = 1'b0, wr = 1'b0, kick = 1'b0, iso, rreq, busy, done, irq;
   logic [2:0] rch = 3'h0, wch = 3'h0;
   logic [15:0] wd = 16'h0000, off = 16'h0000, rdata, pnum, tlvl, snum, dcode, rlev;
   logic [MEAS_CH-1:0][15:0] sec = '0, secb = '0, mref = '0;
   logic [MEAS_CH-1:0] msok = '1, meok = '1, mw34 = '0, mfail, msl, mel;
   logic [STIM_OUTS-1:0][15:0] spos = {STIM_OUTS{16'h4000}}, wrap, scmd;
   logic [STIM_PAIRS-1:0] ssok = '1, seok = '1, son = '1, sw34 = '0, sdrv, ssl, sel;
   logic [STIM_OUTS-1:0] sfail;
   int err_count = 0;
   int check_count = 0;

   // short watchdog period keeps the run brief
   position_converter_test_latch #(.WDOG_CYC(20), .PART_ID(16'h00a5), // arbitrary values
      .SERIAL_ID(16'h0b0b), .DATE_ID(16'h0c0c), .REV_ID(16'h0d0d))
   u_position_converter_test_latch (.CORE_CLK(clk), .RSTN(rst_n),
      .BACKGROUND_CHECK_ENABLE(bg), .INITIATED_CHECK_START(init),
      .INTERFACE_LOOPBACK_CHECK(lb), .IRQ_EN_BG(ieb), .IRQ_EN_INIT(ieb), .STATUS_CLR(clr),
      .LATCH_CMD(lat), .RD_STB(rd), .RD_CHAN(rch), .RD_DATA(rdata), .LB_WR_STB(wr),
      .LB_WR_CHAN(wch), .LB_WR_DATA(wd), .SEC_A(sec), .SEC_B(secb), .MEAS_WIRE34(mw34),
      .MEAS_BIT_REF(mref), .MEAS_ISOLATE(iso), .TEST_LEVEL(tlvl), .STIM_POS(spos),
      .STIM_WIRE34(sw34), .STIM_ON(son), .STIM_WRAP(wrap), .STIM_CMD(scmd), .STIM_DRIVE(sdrv),
      .MEAS_SIG_OK(msok), .MEAS_EXC_OK(meok), .STIM_SIG_OK(ssok), .STIM_EXC_OK(seok),
      .CPU_KICK(kick), .CPU_RST_REQ(rreq), .MEAS_FAIL(mfail), .MEAS_SIG_LOSS(msl),
      .MEAS_EXC_LOSS(mel), .STIM_FAIL(sfail), .STIM_SIG_LOSS(ssl), .STIM_EXC_LOSS(sel),
      .INIT_BUSY(busy), .INIT_DONE_FLAG(done), .IRQ(irq), .PART_NUM(pnum),
      .SERIAL_NUM(snum), .DATE_CODE(dcode), .REV_LEVEL(rlev));
   stim_wrap_model u_stim_wrap_model (.cmd(scmd), .off(off), .wrap(wrap));

   // clock
   initial forever #20 clk = ~clk;

   task chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task rd_chk(input logic [2:0] ch, input logic [15:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      rch <= ch;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask

   task lb_wr(input logic [2:0] ch, input logic [15:0] d);
      @(posedge clk);
      wr <= 1'b1;
      wch <= ch;
      wd <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task pulse_clr;
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
   endtask

   // snapshot survives later writes; a read frees only its channel
   task t_latch;
      @(posedge clk);
      lb <= 1'b1;
      cyc(2);
      chk(16'(iso), 16'h0001);
      lb_wr(3'h0, 16'h1234);
      lb_wr(3'h1, 16'hfedc);
      rd_chk(3'h1, 16'hfedc);
      @(posedge clk);
      lat <= 1'b1;
      @(posedge clk);
      lat <= 1'b0;
      lb_wr(3'h0, 16'h5a5a);
      lb_wr(3'h1, 16'h0f0f);
      rd_chk(3'h0, 16'h1234);
      rd_chk(3'h0, 16'h5a5a);
      rd_chk(3'h1, 16'hfedc);
      chk(scmd[0], 16'h4000);
      @(posedge clk);
      lb <= 1'b0;
   endtask

   // tolerance edge, sticky status, interrupt gating, signal loss
   task t_bg;
      @(posedge clk);
      bg <= 1'b1;
      cyc(300);
      pulse_clr;
      @(posedge clk);
      off <= 16'd132;
      cyc(4);
      chk(16'(sfail), 16'h0001);
      chk(16'(irq), 16'h0000);
      @(posedge clk);
      off <= 16'd0;
      cyc(4);
      chk(16'(sfail), 16'h0001);
      pulse_clr;
      cyc(3);
      chk(16'(sfail), 16'h0000);
      @(posedge clk);
      ieb <= 1'b1;
      off <= 16'd131;
      cyc(4);
      chk(16'(sfail), 16'h0000);
      chk(16'(mfail), 16'h0000);
      @(posedge clk);
      msok <= 8'hf7;
      meok <= 8'hfe;
      ssok <= 6'h3e;
      seok <= 6'h1f;
      cyc(8);
      chk(16'(msl), 16'h0008);
      chk(16'(mel), 16'h0001);
      chk(16'(ssl), 16'h0001);
      chk(16'(sel), 16'h0020);
      chk(16'(irq), 16'h0001);
      @(posedge clk);
      msok <= '1;
      meok <= '1;
      ssok <= '1;
      seok <= '1;
      bg <= 1'b0;
      pulse_clr;
   endtask

   task t_wdog;
      @(posedge clk);
      kick <= ~kick;
      cyc(8);
      chk(16'(rreq), 16'h0000);
      cyc(40);
      chk(16'(rreq), 16'h0001);
   endtask

   // ratio per wiring, old snapshot first; pair 0 shares its A word
   task t_ratio_pair;
      @(posedge clk);
      mw34 <= 8'h04;
      sec[2] <= 16'h3000;
      secb[2] <= 16'h1000;
      sec[3] <= 16'hf000;
      sw34 <= 6'h01;
      spos[0] <= 16'h2222;
      spos[2] <= 16'h1111;
      spos[3] <= 16'h5555;
      cyc(200);
      rd_chk(3'h2, 16'h0000);
      rd_chk(3'h2, 16'h4000);
      rd_chk(3'h3, 16'h0000);
      rd_chk(3'h3, 16'hf000);
      chk(scmd[1], 16'h2222);
      chk(scmd[2], 16'h1111);
      chk(scmd[3], 16'h5555);
   endtask

   // twenty steps of settle and check, then stop from the host side
   task t_init;
      int i;
      @(posedge clk);
      init <= 1'b1;
      cyc(4);
      chk(16'(busy), 16'h0001);
      chk(16'(sdrv), 16'h003f);
      chk(16'(iso), 16'h0001);
      chk(scmd[0], 16'h9000);
      chk(tlvl, 16'h9000);
      for (i = 0; i < 12000 && done !== 1'b1; i++)
         @(posedge clk);
      #1 chk(16'(done), 16'h0001);
      chk(16'(i >= 10000), 16'h0001);
      chk(16'(mfail), 16'h00ff);
      chk(16'(sfail), 16'h0000);
      chk(16'(irq), 16'h0001);
      @(posedge clk);
      init <= 1'b0;
      cyc(2);
      chk(16'(busy), 16'h0000);
   endtask

   task results;
      if (err_count == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // main sequence
   initial
   begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      cyc(4);
      chk(pnum, 16'h00a5);
      chk(snum, 16'h0b0b);
      chk(dcode, 16'h0c0c);
      chk(rlev, 16'h0d0d);
      t_latch;
      t_bg;
      t_wdog;
      t_ratio_pair;
      t_init;
      results;
   end

   // hang guard, about twice the expected run
   initial
   begin
      #(20000 * 40);
      err_count++;
      results;
   end
endmodule
